// *** hdl/dtd_core.sv ***
// Decode and execute of data-transfer instructions with memory bus handshake
`timescale 1ns/1ns
module dtd_core
  import dtd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Instruction stream
  input wire logic insn_valid,
  output logic insn_ready,
  input wire logic [15:0] insn_code,
  input wire logic [31:0] insn_pc,
  // Instruction fetch bus request
  input wire logic fetch_req,
  output logic fetch_grant,
  // Data memory bus
  output logic mem_req,
  output dtd_mem_cmd_s mem_cmd,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // Processor state word condition flag
  input wire logic psw_load,
  input wire logic psw_t_in,
  output logic cond_flag,
  // Status and register peek
  output logic insn_done,
  output logic insn_unsupported,
  input wire logic [3:0] dbg_idx,
  output logic [31:0] dbg_data
);
  typedef struct packed {
    dtd_state_e state;
    logic ld_pend;
    logic [3:0] ld_dst;
    logic owed;
    dtd_mem_cmd_s cmd;
    logic cond_flag;
    logic done;
    logic unsup;
    logic [31:0] dbg;
  } dtd_core_s;

  dtd_core_s st;
  dtd_core_s next_st;

  logic [3:0] f_n;
  logic [3:0] f_m;
  logic [3:0] f_op;
  logic [1:0] f_sz;
  logic [31:0] ra;
  logic [31:0] rb;
  logic [31:0] r0;
  logic [31:0] rf_dbg;
  logic [31:0] pc_base;
  logic is_mem;
  logic is_load;
  logic bad;
  logic [1:0] d_size;
  logic [31:0] d_addr;
  logic [31:0] d_wdata;
  logic [3:0] d_dst;
  logic wa_en;
  logic [3:0] wa_idx;
  logic [31:0] wa_data;
  logic wb_en;
  logic [31:0] wb_data;
  logic [15:0] rd_mask;
  logic e_finish;
  logic hazard;
  logic accept;

  assign f_op = insn_code[15:12];
  assign f_n = insn_code[11:8];
  assign f_m = insn_code[7:4];
  assign f_sz = insn_code[1:0];
  assign pc_base = insn_pc + PC_AHEAD;

  dtd_regfile #(.NREG(16)) u_rf (
    .mclk(mclk),
    .rst(rst),
    .wa_en(wa_en && accept),
    .wa_idx(wa_idx),
    .wa_data(wa_data),
    .wb_en(wb_en),
    .wb_idx(st.ld_dst),
    .wb_data(wb_data),
    .ra_idx(f_m),
    .ra_data(ra),
    .rb_idx(f_n),
    .rb_data(rb),
    .r0_data(r0),
    .dbg_idx(dbg_idx),
    .dbg_data(rf_dbg)
  );

  // ==========================================================================
  // Instruction decode
  always_comb
  begin
    is_mem = 1'b0;
    is_load = 1'b0;
    bad = 1'b0;
    d_size = SZ_L;
    d_addr = '0;
    d_wdata = '0;
    d_dst = f_n;
    wa_en = 1'b0;
    wa_idx = f_n;
    wa_data = '0;
    rd_mask = '0;
    case (f_op)
      OP_IMM:
      begin
        wa_en = 1'b1;
        wa_data = dtd_sext({24'h00_0000, insn_code[7:0]}, SZ_B);
      end
      OP_PCW:
      begin
        is_mem = 1'b1;
        is_load = 1'b1;
        d_size = SZ_W;
        d_addr = pc_base + {23'h00_0000, insn_code[7:0], 1'b0};
      end
      OP_PCL:
      begin
        is_mem = 1'b1;
        is_load = 1'b1;
        d_addr = (pc_base & LONG_MASK) + {22'h00_0000, insn_code[7:0], 2'h0};
      end
      OP_LDG:
      begin
        rd_mask[f_m] = 1'b1;
        if (insn_code[3:0] == LO_COPY)
        begin
          wa_en = 1'b1;
          wa_data = ra;
        end
        else if (f_sz != SZ_BAD && (insn_code[3:2] == MD_IND || insn_code[3:2] == MD_AUTO))
        begin
          is_mem = 1'b1;
          is_load = 1'b1;
          d_size = f_sz;
          d_addr = ra;
          if (insn_code[3:2] == MD_AUTO)
          begin
            wa_en = 1'b1;
            wa_idx = f_m;
            wa_data = ra + dtd_step(f_sz);
          end
        end
        else
          bad = 1'b1;
      end
      OP_STG:
      begin
        rd_mask[f_m] = 1'b1;
        rd_mask[f_n] = 1'b1;
        d_wdata = ra;
        d_size = f_sz;
        if (f_sz != SZ_BAD && insn_code[3:2] == MD_IND)
        begin
          is_mem = 1'b1;
          d_addr = rb;
        end
        else if (f_sz != SZ_BAD && insn_code[3:2] == MD_AUTO)
        begin
          is_mem = 1'b1;
          wa_en = 1'b1;
          wa_data = rb - dtd_step(f_sz);
          d_addr = wa_data;
        end
        else
          bad = 1'b1;
      end
      OP_IDX:
      begin
        rd_mask[f_m] = 1'b1;
        rd_mask[f_n] = 1'b1;
        rd_mask[R0_IDX] = 1'b1;
        d_size = f_sz;
        if (f_sz != SZ_BAD && insn_code[3:2] == MD_AUTO)
        begin
          is_mem = 1'b1;
          d_wdata = ra;
          d_addr = r0 + rb;
        end
        else if (f_sz != SZ_BAD && insn_code[3:2] == MD_IDXLD)
        begin
          is_mem = 1'b1;
          is_load = 1'b1;
          d_addr = r0 + ra;
        end
        else
          bad = 1'b1;
      end
      OP_STDL:
      begin
        rd_mask[f_m] = 1'b1;
        rd_mask[f_n] = 1'b1;
        is_mem = 1'b1;
        d_wdata = ra;
        d_addr = rb + {26'h000_0000, insn_code[3:0], 2'h0};
      end
      OP_LDDL:
      begin
        rd_mask[f_m] = 1'b1;
        is_mem = 1'b1;
        is_load = 1'b1;
        d_addr = ra + {26'h000_0000, insn_code[3:0], 2'h0};
      end
      OP_DSP:
      begin
        rd_mask[f_m] = 1'b1;
        rd_mask[R0_IDX] = 1'b1;
        d_wdata = r0;
        d_dst = R0_IDX;
        is_mem = 1'b1;
        case (f_n)
          DSP_STB:
          begin
            d_size = SZ_B;
            d_addr = ra + {28'h000_0000, insn_code[3:0]};
          end
          DSP_STW:
          begin
            d_size = SZ_W;
            d_addr = ra + {27'h000_0000, insn_code[3:0], 1'b0};
          end
          DSP_LDB:
          begin
            is_load = 1'b1;
            d_size = SZ_B;
            d_addr = ra + {28'h000_0000, insn_code[3:0]};
          end
          DSP_LDW:
          begin
            is_load = 1'b1;
            d_size = SZ_W;
            d_addr = ra + {27'h000_0000, insn_code[3:0], 1'b0};
          end
          default:
          begin
            is_mem = 1'b0;
            bad = 1'b1;
          end
        endcase
      end
      default:
        bad = 1'b1;
    endcase
  end

  // ==========================================================================
  // Bus arbitration, interlock and handshake
  assign mem_req = (st.state == ST_MEM) && (!fetch_req || st.owed);
  assign fetch_grant = fetch_req && !mem_req;
  assign e_finish = mem_req && mem_ack;
  assign hazard = (st.state == ST_MEM) && st.ld_pend && rd_mask[st.ld_dst];
  assign insn_ready = ((st.state == ST_IDLE) || e_finish) && !hazard;
  assign accept = insn_valid && insn_ready;
  assign wb_en = e_finish && st.ld_pend;
  assign wb_data = dtd_sext(mem_rdata, st.cmd.size);

  // ==========================================================================
  // State update
  always_comb
  begin
    next_st = st;
    next_st.done = e_finish || (accept && !is_mem);
    next_st.unsup = accept && bad;
    next_st.dbg = rf_dbg;
    if (psw_load)
      next_st.cond_flag = psw_t_in;
    if (st.state == ST_MEM && !mem_req)
      next_st.owed = 1'b1;
    if (e_finish)
    begin
      next_st.state = ST_IDLE;
      next_st.ld_pend = 1'b0;
      next_st.owed = 1'b0;
    end
    if (accept && is_mem)
    begin
      next_st.state = ST_MEM;
      next_st.ld_pend = is_load;
      next_st.ld_dst = d_dst;
      next_st.owed = 1'b0;
      next_st.cmd.we = !is_load;
      next_st.cmd.size = d_size;
      next_st.cmd.addr = d_addr;
      next_st.cmd.wdata = d_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign mem_cmd = st.cmd;
  assign cond_flag = st.cond_flag;
  assign insn_done = st.done;
  assign insn_unsupported = st.unsup;
  assign dbg_data = st.dbg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_mem_issue;
    accept && is_mem && !fetch_req;
  endsequence
  sequence s_no_wait;
    mem_req && mem_ack;
  endsequence
  property p_one_cycle;
    s_mem_issue ##1 s_no_wait |=> insn_done;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("No-wait transfer did not finish in one cycle");
  property p_contend;
    (st.state == ST_MEM && fetch_req && !st.owed) |-> (!mem_req && fetch_grant) ##1 (st.state != ST_MEM || mem_req);
  endproperty
  a_contend: assert property (p_contend) else $error("Fetch contention not resolved");
  property p_interlock;
    (st.state == ST_MEM && st.ld_pend && insn_valid && rd_mask[st.ld_dst]) |-> !accept;
  endproperty
  a_interlock: assert property (p_interlock) else $error("Dependent instruction accepted during load");
  property p_copy;
    (accept && f_op == OP_LDG && insn_code[3:0] == LO_COPY) |-> wa_en && wa_idx == f_n && wa_data == ra;
  endproperty
  a_copy: assert property (p_copy) else $error("Register copy to wrong register");
  property p_flag;
    !psw_load |=> $stable(cond_flag);
  endproperty
  a_flag: assert property (p_flag) else $error("Condition flag changed by transfer");
  property p_imm;
    (accept && f_op == OP_IMM) |-> wa_en && wa_data[31:7] == {25{insn_code[7]}} && wa_data[7:0] == insn_code[7:0];
  endproperty
  a_imm: assert property (p_imm) else $error("Immediate not sign-extended");
  property p_pcl;
    (accept && f_op == OP_PCL) |=> mem_cmd.addr[1:0] == 2'h0 && mem_cmd.size == SZ_L && !mem_cmd.we;
  endproperty
  a_pcl: assert property (p_pcl) else $error("Longword PC load misaligned");
  property p_pcw;
    (accept && f_op == OP_PCW) |=> mem_cmd.addr == $past(insn_pc) + 32'h0000_0004 + {23'h0, $past(insn_code[7:0]), 1'b0};
  endproperty
  a_pcw: assert property (p_pcw) else $error("Word PC load address wrong");
  property p_sext_b;
    (wb_en && st.cmd.size == SZ_B) |-> wb_data[31:8] == {24{mem_rdata[7]}};
  endproperty
  a_sext_b: assert property (p_sext_b) else $error("Byte load not sign-extended");
  property p_predec;
    (accept && f_op == OP_STG && insn_code[3:2] == MD_AUTO && f_sz == SZ_L) |-> wa_data == rb - 32'h0000_0004
      ##1 mem_cmd.addr == $past(wa_data) && mem_cmd.we;
  endproperty
  a_predec: assert property (p_predec) else $error("Pre-decrement store wrong");
  property p_disp_r0;
    (accept && f_op == OP_DSP && (f_n == DSP_LDB || f_n == DSP_LDW)) |=> st.ld_dst == R0_IDX && st.ld_pend;
  endproperty
  a_disp_r0: assert property (p_disp_r0) else $error("Displacement load not aimed at register 0");
endmodule // dtd_core

// *** hdl/dtd_pkg.sv ***
// Constants, types and helper functions for the data-transfer instruction unit
// Notes on behaviour
// - A transfer instruction takes one execution cycle when memory answers without wait states, more otherwise.
// - When an instruction fetch and a data access want the bus in the same cycle, the instruction is stretched.
// - An instruction that reads the register a pending memory load is writing is held back until the load is done.
// - The 4-bit source and destination register fields select registers 0 to 15 by their binary value.
// - No transfer instruction changes the condition flag of the processor state word.
// - The immediate move sign-extends the 8-bit literal and writes it to the destination register.
// - The PC-relative word load reads at PC plus displacement times two and sign-extends the word.
// - The PC-relative longword load reads at PC plus displacement times four and writes the data as read.
// - Register-indirect loads read at the source register; byte and word data are sign-extended.
// - Pre-decrement stores first lower the destination register by 1, 2 or 4, then store at the new address.
// - Post-increment loads read at the source register, then raise it by 1, 2 or 4.
// - Byte and word stores of register 0 go to base plus 4-bit displacement scaled by 1 or 2.
// - Longword displacement stores and loads use any register with base plus displacement times four.
// - Byte and word displacement loads sign-extend the data and always write register 0.
// - Indexed stores write the source register to register 0 plus the destination register.
package dtd_pkg;
  // ==========================================================================
  // Sizes and opcode fields
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_W = 2'h1;
  localparam logic [1:0] SZ_L = 2'h2;
  localparam logic [1:0] SZ_BAD = 2'h3;
  localparam logic [3:0] OP_IMM = 4'he;
  localparam logic [3:0] OP_PCW = 4'h9;
  localparam logic [3:0] OP_PCL = 4'hd;
  localparam logic [3:0] OP_LDG = 4'h6;
  localparam logic [3:0] OP_STG = 4'h2;
  localparam logic [3:0] OP_IDX = 4'h0;
  localparam logic [3:0] OP_STDL = 4'h1;
  localparam logic [3:0] OP_LDDL = 4'h5;
  localparam logic [3:0] OP_DSP = 4'h8;
  localparam logic [3:0] DSP_STB = 4'h0;
  localparam logic [3:0] DSP_STW = 4'h1;
  localparam logic [3:0] DSP_LDB = 4'h4;
  localparam logic [3:0] DSP_LDW = 4'h5;
  localparam logic [3:0] LO_COPY = 4'h3;
  localparam logic [1:0] MD_IND = 2'h0;
  localparam logic [1:0] MD_AUTO = 2'h1;
  localparam logic [1:0] MD_IDXLD = 2'h3;
  localparam logic [3:0] R0_IDX = 4'h0;
  localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
  localparam logic [31:0] LONG_MASK = 32'hffff_fffc;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_MEM = 2'h1} dtd_state_e;

  typedef struct packed {
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dtd_mem_cmd_s;

  // ==========================================================================
  // Shared decoding
  function automatic logic [31:0] dtd_step(input logic [1:0] size);
    case (size)
      SZ_B: dtd_step = 32'h0000_0001;
      SZ_W: dtd_step = 32'h0000_0002;
      default: dtd_step = 32'h0000_0004;
    endcase
  endfunction

  function automatic logic [31:0] dtd_sext(input logic [31:0] d, input logic [1:0] size);
    case (size)
      SZ_B: dtd_sext = {{24{d[7]}}, d[7:0]};
      SZ_W: dtd_sext = {{16{d[15]}}, d[15:0]};
      default: dtd_sext = d;
    endcase
  endfunction
endpackage

// *** hdl/dtd_regfile.sv ***
// General register file with two write ports and four read ports
`timescale 1ns/1ns
module dtd_regfile
  import dtd_pkg::*;
#(
  parameter int NREG = 16
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Accept-time write, wins over the load port
  input wire logic wa_en,
  input wire logic [3:0] wa_idx,
  input wire logic [31:0] wa_data,
  // Load write-back
  input wire logic wb_en,
  input wire logic [3:0] wb_idx,
  input wire logic [31:0] wb_data,
  // Reads
  input wire logic [3:0] ra_idx,
  output logic [31:0] ra_data,
  input wire logic [3:0] rb_idx,
  output logic [31:0] rb_data,
  output logic [31:0] r0_data,
  input wire logic [3:0] dbg_idx,
  output logic [31:0] dbg_data
);
  if (NREG != 16) begin : g_chk
    $error("dtd_regfile: four-bit fields need exactly 16 registers");
  end

  typedef struct packed {
    logic [NREG-1:0][31:0] regs;
  } dtd_rf_s;

  dtd_rf_s st;
  dtd_rf_s next_st;

  // ==========================================================================
  // Write ports
  always_comb
  begin
    next_st = st;
    for (int i = 0; i < NREG; i++)
    begin
      if (wa_en && wa_idx == 4'(i))
        next_st.regs[i] = wa_data;
      else if (wb_en && wb_idx == 4'(i))
        next_st.regs[i] = wb_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  // ==========================================================================
  // Read ports, field value is the register number
  assign ra_data = st.regs[ra_idx];
  assign rb_data = st.regs[rb_idx];
  assign r0_data = st.regs[R0_IDX];
  assign dbg_data = st.regs[dbg_idx];
endmodule // dtd_regfile

// *** verification/dtd_mem_model.sv ***
// Data memory partner model with programmable wait states
`timescale 1ns/1ns
module dtd_mem_model
  import dtd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Data bus from the core
  input wire logic mem_req,
  input wire dtd_mem_cmd_s mem_cmd,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  // Test control and observation
  input wire logic [3:0] waits,
  output dtd_mem_cmd_s last_cmd,
  output logic [7:0] cmd_err
);
  logic [3:0] cnt;
  logic busy;
  logic [31:0] noise;
  dtd_mem_cmd_s held;

  // ==========================================================================
  // Answer after the programmed number of wait cycles
  assign mem_ack = mem_req && (cnt == waits);
  assign mem_rdata = mem_ack ? (mem_cmd.addr ^ 32'hc3a5_9687) : noise;

  // ==========================================================================
  // Access tracking and command stability watch
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt <= 4'h0;
      busy <= 1'b0;
      noise <= 32'h0f0f_0f0f;
      held <= '0;
      last_cmd <= '0;
      cmd_err <= 8'h00;
    end
    else
    begin
      noise <= noise + 32'h9e37_79b9;
      if (busy && (mem_cmd != held))
        cmd_err <= cmd_err + 8'h01;
      if (mem_ack)
      begin
        cnt <= 4'h0;
        busy <= 1'b0;
        last_cmd <= mem_cmd;
      end
      else if (mem_req)
      begin
        cnt <= cnt + 4'h1;
        busy <= 1'b1;
        held <= mem_cmd;
      end
    end
  end
endmodule // dtd_mem_model

// *** verification/tb_data_transfer_insn_decode.sv ***
// Self-checking bench for the data-transfer instruction unit
`timescale 1ns/1ns
module tb_data_transfer_insn_decode
  import dtd_pkg::*;
();
  typedef struct packed {
    logic [15:0] code;
    logic [31:0] pc;
    logic [3:0] ridx;
    logic [31:0] rval;
    logic mem;
    dtd_mem_cmd_s cmd;
  } dtd_row_s;
  localparam int LIMIT = 3000;
  logic mclk, rst, insn_valid, insn_ready, fetch_req, fetch_grant, mem_req, mem_ack;
  logic psw_load, psw_t_in, cond_flag, insn_done, insn_unsupported;
  logic [15:0] insn_code;
  logic [31:0] insn_pc, mem_rdata, dbg_data, wm;
  logic [3:0] dbg_idx, waits;
  logic [7:0] cmd_err;
  dtd_mem_cmd_s mem_cmd, last_cmd;
  dtd_row_s rows[$];
  int bad_count, num_checks, cyc, lat, n;

  // ==========================================================================
  // Design and memory partner
  dtd_core u_dut (.mclk(mclk), .rst(rst), .insn_valid(insn_valid), .insn_ready(insn_ready),
    .insn_code(insn_code), .insn_pc(insn_pc), .fetch_req(fetch_req), .fetch_grant(fetch_grant),
    .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .psw_load(psw_load), .psw_t_in(psw_t_in), .cond_flag(cond_flag), .insn_done(insn_done),
    .insn_unsupported(insn_unsupported), .dbg_idx(dbg_idx), .dbg_data(dbg_data));
  dtd_mem_model u_mem (.mclk(mclk), .rst(rst), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .waits(waits), .last_cmd(last_cmd), .cmd_err(cmd_err));

  // ==========================================================================
  // Clock and timeout
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      bad_count++;
      close_out();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic add(input logic [15:0] c, input logic [31:0] p, input logic [3:0] r, input logic [31:0] v,
                     input logic m, input logic w, input logic [1:0] s, input logic [31:0] a, input logic [31:0] d);
    rows.push_back('{c, p, r, v, m, '{w, s, a, d}});
  endtask

  task automatic rd_reg(input logic [3:0] idx, input logic [31:0] exp);
    dbg_idx = idx;
    @(posedge mclk);
    #1;
    chk(dbg_data, exp);
  endtask

  task automatic run_insn(input logic [15:0] c, input logic [31:0] p, output int l);
    int k;
    k = 0;
    insn_valid = 1'b1;
    insn_code = c;
    insn_pc = p;
    #1;
    while (insn_ready !== 1'b1 && k < 50)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    @(posedge mclk);
    #1;
    insn_valid = 1'b0;
    insn_code = 16'h0000;
    l = 1;
    while (insn_done !== 1'b1 && l < 50)
    begin
      @(posedge mclk);
      #1;
      l++;
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    insn_valid = 1'b0;
    insn_code = 16'h0000;
    insn_pc = 32'h0000_0000;
    fetch_req = 1'b0;
    psw_load = 1'b0;
    psw_t_in = 1'b0;
    dbg_idx = 4'h0;
    waits = 4'h0;
    repeat (3) @(posedge mclk);
    #1;
    chk(insn_ready, 1'b1);
    chk(mem_req, 1'b0);
    rst = 1'b0;
    psw_load = 1'b1;
    psw_t_in = 1'b1;
    @(posedge mclk);
    #1;
    psw_load = 1'b0;
    rd_reg(4'h9, 32'h0000_0000);
    add(16'he180, 32'h0, 4'h1, 32'hffff_ff80, 0, 0, SZ_B, 32'h0, 32'h0);
    add(16'he27f, 32'h0, 4'h2, 32'h0000_007f, 0, 0, SZ_B, 32'h0, 32'h0);
    add(16'hef10, 32'h0, 4'hf, 32'h0000_0010, 0, 0, SZ_B, 32'h0, 32'h0);
    add(16'h6313, 32'h0, 4'h3, 32'hffff_ff80, 0, 0, SZ_B, 32'h0, 32'h0);
    add(16'h6420, 32'h0, 4'h4, 32'hffff_fff8, 1, 0, SZ_B, 32'h7f, 32'h0);
    add(16'h6521, 32'h0, 4'h5, 32'hffff_96f8, 1, 0, SZ_W, 32'h7f, 32'h0);
    add(16'h6622, 32'h0, 4'h6, 32'hc3a5_96f8, 1, 0, SZ_L, 32'h7f, 32'h0);
    add(16'h67f6, 32'h0, 4'h7, 32'hc3a5_9697, 1, 0, SZ_L, 32'h10, 32'h0);
    add(16'h68f4, 32'h0, 4'h8, 32'hffff_ff93, 1, 0, SZ_B, 32'h14, 32'h0);
    add(16'h69f5, 32'h0, 4'h9, 32'hffff_9692, 1, 0, SZ_W, 32'h15, 32'h0);
    add(16'h2f26, 32'h0, 4'hf, 32'h0000_0013, 1, 1, SZ_L, 32'h13, 32'h7f);
    add(16'h2f24, 32'h0, 4'hf, 32'h0000_0012, 1, 1, SZ_B, 32'h12, 32'h7f);
    add(16'h2f25, 32'h0, 4'hf, 32'h0000_0010, 1, 1, SZ_W, 32'h10, 32'h7f);
    add(16'he004, 32'h0, 4'h0, 32'h0000_0004, 0, 0, SZ_B, 32'h0, 32'h0);
    add(16'h80f3, 32'h0, 4'hf, 32'h0000_0010, 1, 1, SZ_B, 32'h13, 32'h4);
    add(16'h81f3, 32'h0, 4'hf, 32'h0000_0010, 1, 1, SZ_W, 32'h16, 32'h4);
    add(16'h1f23, 32'h0, 4'h2, 32'h0000_007f, 1, 1, SZ_L, 32'h1c, 32'h7f);
    add(16'h5af3, 32'h0, 4'ha, 32'hc3a5_969b, 1, 0, SZ_L, 32'h1c, 32'h0);
    add(16'h84f1, 32'h0, 4'h0, 32'hffff_ff96, 1, 0, SZ_B, 32'h11, 32'h0);
    add(16'h85f1, 32'h0, 4'h0, 32'hffff_9695, 1, 0, SZ_W, 32'h12, 32'h0);
    add(16'he008, 32'h0, 4'h0, 32'h0000_0008, 0, 0, SZ_B, 32'h0, 32'h0);
    add(16'h0f24, 32'h0, 4'hf, 32'h0000_0010, 1, 1, SZ_B, 32'h18, 32'h7f);
    add(16'h0f25, 32'h0, 4'hf, 32'h0000_0010, 1, 1, SZ_W, 32'h18, 32'h7f);
    add(16'h2f22, 32'h0, 4'hf, 32'h0000_0010, 1, 1, SZ_L, 32'h10, 32'h7f);
    add(16'h0dfc, 32'h0, 4'hd, 32'hffff_ff9f, 1, 0, SZ_B, 32'h18, 32'h0);
    add(16'h0efe, 32'h0, 4'he, 32'hc3a5_969f, 1, 0, SZ_L, 32'h18, 32'h0);
    add(16'h9b05, 32'h1000, 4'hb, 32'hffff_8689, 1, 0, SZ_W, 32'h100e, 32'h0);
    add(16'hdc03, 32'h1002, 4'hc, 32'hc3a5_8697, 1, 0, SZ_L, 32'h1010, 32'h0);
    foreach (rows[i])
    begin
      run_insn(rows[i].code, rows[i].pc, lat);
      chk(lat, rows[i].mem ? 2 : 1);
      if (rows[i].mem)
      begin
        wm = (rows[i].cmd.size == SZ_B) ? 32'h0000_00ff : (rows[i].cmd.size == SZ_W) ? 32'h0000_ffff : 32'hffff_ffff;
        chk({last_cmd.we, last_cmd.size}, {rows[i].cmd.we, rows[i].cmd.size});
        chk(last_cmd.addr, rows[i].cmd.addr);
        if (rows[i].cmd.we)
          chk(last_cmd.wdata & wm, rows[i].cmd.wdata);
      end
      rd_reg(rows[i].ridx, rows[i].rval);
    end
    $display("test table done");
    waits = 4'h3;
    run_insn(16'h6422, 32'h0, lat);
    chk(lat, 5);
    chk(cmd_err, 8'h00);
    rd_reg(4'h4, 32'hc3a5_96f8);
    waits = 4'h0;
    $display("test wait states done");
    insn_valid = 1'b1;
    insn_code = 16'h6522;
    @(posedge mclk);
    #1;
    insn_valid = 1'b0;
    fetch_req = 1'b1;
    #1;
    chk({fetch_grant, mem_req}, 2'b10);
    @(posedge mclk);
    #1;
    chk({fetch_grant, mem_req}, 2'b01);
    @(posedge mclk);
    #1;
    fetch_req = 1'b0;
    chk(insn_done, 1'b1);
    rd_reg(4'h5, 32'hc3a5_96f8);
    $display("test contention done");
    waits = 4'h2;
    insn_valid = 1'b1;
    insn_code = 16'h6622;
    @(posedge mclk);
    #1;
    insn_code = 16'h6363;
    #1;
    chk(insn_ready, 1'b0);
    n = 0;
    while (insn_ready !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(n > 2, 1'b1);
    @(posedge mclk);
    #1;
    insn_valid = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rd_reg(4'h3, 32'hc3a5_96f8);
    waits = 4'h0;
    $display("test interlock done");
    run_insn(16'h6427, 32'h0, lat);
    chk(insn_unsupported, 1'b1);
    rd_reg(4'h4, 32'hc3a5_96f8);
    chk(cond_flag, 1'b1);
    $display("test unsupported and flag done");
    rst = 1'b1;
    @(posedge mclk);
    #1;
    chk({cond_flag, mem_req, insn_ready}, 3'b001);
    rst = 1'b0;
    rd_reg(4'h1, 32'h0000_0000);
    $display("test second reset done");
    close_out();
  end
endmodule // tb_data_transfer_insn_decode
